/* File: core/pewp_host.sv */
// host controller that drives a paged parallel eeprom over its pins
// assumes pins are synchronous to clk_i and the user holds req until ready
`timescale 1ns/1ps
`default_nettype none

// How it works
// - whole page load keeps one page address
// - output drive held high during write strobe
// - next byte sent inside byte_load_window
// - one to 128 bytes follow enable sequence (t_lock also sends it with none after it, and the model still locks)
// - command bytes hex, addresses use low 15
module pewp_host #(
	parameter int BLC_CYCLES = pewp_pkg::BLC_CYC,
	parameter int WC_CYCLES = pewp_pkg::WC_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// user request port
	input wire logic req_valid_i,
	input wire pewp_pkg::pewp_req_s req_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output logic [pewp_pkg::DATA_W-1:0] rsp_data_o,
	output logic busy_o,
	output logic page_err_o,
	// eeprom pins
	output logic ce_n_o,
	output logic oe_n_o,
	output logic we_n_o,
	output logic [pewp_pkg::ADDR_W-1:0] addr_o,
	output logic [pewp_pkg::DATA_W-1:0] data_lines_o,
	output logic data_lines_oe_o,
	input wire logic [pewp_pkg::DATA_W-1:0] data_lines_i
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum {
		S_IDLE,
		S_WLOW,
		S_WHIGH,
		S_RD,
		S_WAITPROG
	} pewp_state_e;

	pewp_state_e state_q; // sequencer state
	pewp_pkg::pewp_pins_s pins_q; // registered pins
	logic [pewp_pkg::CNT_W-1:0] tmr_q; // phase timer
	logic [pewp_pkg::CNT_W-1:0] blc_q; // byte_load_window timer
	logic in_page_q; // a page load is open
	logic [pewp_pkg::ADDR_W-pewp_pkg::PAGE_LSB-1:0] page_q; // open page
	logic last_q; // current byte closes page
	logic poll_q; // current read is a poll
	logic [pewp_pkg::DATA_W-1:0] last_byte_q; // last byte written
	logic rsp_valid_q; // answer strobe
	logic [pewp_pkg::DATA_W-1:0] rsp_data_q; // answer data
	logic err_q; // page mismatch flag
	logic req_page_ok; // request page matches open page

	assign req_page_ok = !in_page_q ||
		(req_i.addr[pewp_pkg::ADDR_W-1:pewp_pkg::PAGE_LSB] == page_q);
	assign req_ready_o = (state_q == S_IDLE);
	assign busy_o = (state_q != S_IDLE) || in_page_q;
	assign rsp_valid_o = rsp_valid_q;
	assign rsp_data_o = rsp_data_q;
	assign page_err_o = err_q;
	assign ce_n_o = pins_q.ce_n;
	assign oe_n_o = pins_q.oe_n;
	assign we_n_o = pins_q.we_n;
	assign addr_o = pins_q.addr;
	assign data_lines_o = pins_q.dq;
	assign data_lines_oe_o = pins_q.dq_oe;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	// one process drives pins and state together so they never disagree
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= S_IDLE;
			pins_q <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq: '0, dq_oe: 1'b0};
			tmr_q <= pewp_pkg::CNT_ZERO;
			poll_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			unique case (state_q)
				// idle: start a read or write
				S_IDLE: begin
					if (req_valid_i && req_i.op == pewp_pkg::PEWP_OP_WRITE && req_page_ok) begin
						pins_q.oe_n <= 1'b1;
						// full address and data, falling strobes
						pins_q.addr <= req_i.addr;
						pins_q.dq <= req_i.data;
						pins_q.dq_oe <= 1'b1;
						pins_q.ce_n <= 1'b0;
						pins_q.we_n <= 1'b0;
						last_q <= req_i.last;
						tmr_q <= pewp_pkg::CNT_W'(pewp_pkg::WP_CYC);
						state_q <= S_WLOW;
					end else if (req_valid_i && req_i.op != pewp_pkg::PEWP_OP_WRITE) begin
						pins_q.addr <= req_i.addr;
						pins_q.dq_oe <= 1'b0;
						pins_q.ce_n <= 1'b0;
						pins_q.oe_n <= 1'b0;
						poll_q <= (req_i.op == pewp_pkg::PEWP_OP_POLL);
						tmr_q <= pewp_pkg::CNT_W'(pewp_pkg::ACC_CYC);
						state_q <= S_RD;
					end
				end
				// write strobe low
				S_WLOW: begin
					if (tmr_q == pewp_pkg::CNT_ONE) begin
						pins_q.we_n <= 1'b1;
						pins_q.ce_n <= 1'b1;
						tmr_q <= pewp_pkg::CNT_W'(pewp_pkg::WPH_CYC);
						state_q <= S_WHIGH;
					end else begin
						tmr_q <= tmr_q - pewp_pkg::CNT_ONE;
					end
				end
				// strobe high recovery, release data bus
				S_WHIGH: begin
					pins_q.dq_oe <= 1'b0;
					if (tmr_q == pewp_pkg::CNT_ONE) begin
						// closing byte lets window run out
						if (last_q) begin
							tmr_q <= pewp_pkg::CNT_W'(BLC_CYCLES + WC_CYCLES);
							state_q <= S_WAITPROG;
						end else begin
							state_q <= S_IDLE;
						end
					end else begin
						tmr_q <= tmr_q - pewp_pkg::CNT_ONE;
					end
				end
				// read access time
				S_RD: begin
					if (tmr_q == pewp_pkg::CNT_ONE) begin
						pins_q.ce_n <= 1'b1;
						pins_q.oe_n <= 1'b1;
						state_q <= S_IDLE;
					end else begin
						tmr_q <= tmr_q - pewp_pkg::CNT_ONE;
					end
				end
				S_WAITPROG: begin
					if (tmr_q == pewp_pkg::CNT_ONE) begin
						state_q <= S_IDLE;
					end else begin
						tmr_q <= tmr_q - pewp_pkg::CNT_ONE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// page load tracking
	// ----------------------------------------
	// the window restarts at every byte
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			in_page_q <= 1'b0;
			page_q <= '0;
			blc_q <= pewp_pkg::CNT_ZERO;
			last_byte_q <= '0;
		end else if (state_q == S_WLOW && tmr_q == pewp_pkg::CNT_ONE) begin
			in_page_q <= !last_q;
			page_q <= pins_q.addr[pewp_pkg::ADDR_W-1:pewp_pkg::PAGE_LSB];
			blc_q <= pewp_pkg::CNT_W'(BLC_CYCLES);
			last_byte_q <= pins_q.dq;
		end else if (in_page_q && blc_q != pewp_pkg::CNT_ZERO) begin
			blc_q <= blc_q - pewp_pkg::CNT_ONE;
			if (blc_q == pewp_pkg::CNT_ONE) begin
				in_page_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// answers and error
	// ----------------------------------------
	// poll answers the poll bit match
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rsp_valid_q <= 1'b0;
			rsp_data_q <= '0;
			err_q <= 1'b0;
		end else begin
			rsp_valid_q <= (state_q == S_RD) && (tmr_q == pewp_pkg::CNT_ONE);
			if (state_q == S_RD && tmr_q == pewp_pkg::CNT_ONE) begin
				rsp_data_q <= poll_q ?
					{7'h00, data_lines_i[pewp_pkg::POLL_BIT] == last_byte_q[pewp_pkg::POLL_BIT]} :
					data_lines_i;
			end
			// refuse a write to another page
			if (req_valid_i && state_q == S_IDLE && req_i.op == pewp_pkg::PEWP_OP_WRITE) begin
				err_q <= !req_page_ok;
			end
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_oe_high_in_write;
		@(posedge clk_i) disable iff (!rst_n_i) (!we_n_o && !ce_n_o) |-> oe_n_o;
	endproperty
	a_oe_high_in_write: assert property (p_oe_high_in_write)
		else $error("output drive low during write strobe");

	property p_page_same;
		@(posedge clk_i) disable iff (!rst_n_i)
			($fell(we_n_o) && in_page_q) |->
			(addr_o[pewp_pkg::ADDR_W-1:pewp_pkg::PAGE_LSB] == page_q);
	endproperty
	a_page_same: assert property (p_page_same)
		else $error("page address changed in a page load");

	// strobe low length, counted for the width check
	logic [7:0] we_low_q; // cycles the write strobe has stayed low
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) we_low_q <= 8'h00;
		else we_low_q <= we_n_o ? 8'h00 : we_low_q + 8'h01;
	end
	property p_strobe_width;
		@(posedge clk_i) disable iff (!rst_n_i)
			$rose(we_n_o) |-> we_low_q >= 8'(pewp_pkg::WP_CYC);
	endproperty
	a_strobe_width: assert property (p_strobe_width)
		else $error("write strobe low too short");

	property p_data_driven;
		@(posedge clk_i) disable iff (!rst_n_i) !we_n_o |-> data_lines_oe_o;
	endproperty
	a_data_driven: assert property (p_data_driven)
		else $error("data not driven while strobe low");

	property p_no_drive_on_read;
		@(posedge clk_i) disable iff (!rst_n_i) !oe_n_o |-> !data_lines_oe_o;
	endproperty
	a_no_drive_on_read: assert property (p_no_drive_on_read)
		else $error("bus contention on read");

	property p_window_bound;
		@(posedge clk_i) disable iff (!rst_n_i) blc_q <= pewp_pkg::CNT_W'(BLC_CYCLES);
	endproperty
	a_window_bound: assert property (p_window_bound)
		else $error("byte load window overrun");

	property p_last_waits;
		@(posedge clk_i) disable iff (!rst_n_i)
			(state_q == S_WHIGH && last_q && tmr_q == pewp_pkg::CNT_ONE) |=> state_q == S_WAITPROG;
	endproperty
	a_last_waits: assert property (p_last_waits)
		else $error("program time not waited");

	property p_read_answer;
		@(posedge clk_i) disable iff (!rst_n_i)
			(req_valid_i && req_ready_o && req_i.op == pewp_pkg::PEWP_OP_READ) |-> ##17 rsp_valid_o;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("read answer late");

	c_write: cover property (@(posedge clk_i) $rose(we_n_o));
	c_read: cover property (@(posedge clk_i) rsp_valid_o);
	c_prog: cover property (@(posedge clk_i) state_q == S_WAITPROG);
	c_err: cover property (@(posedge clk_i) page_err_o);

endmodule // pewp_host

`default_nettype wire

/* File: core/pewp_pkg.sv */
// package for the paged eeprom host-side write port controller
// assumes a single 100 MHz clock and a clockless eeprom on the pins
package pewp_pkg;

	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int ADDR_W = 17; // full address width
	localparam int DATA_W = 8; // data lines
	localparam int PAGE_LSB = 7; // first page address line
	localparam int PAGE_BYTES = 128; // bytes per page
	localparam int CMD_ADDR_W = 15; // command address decode width
	localparam int POLL_BIT = 7; // poll data bit position

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10; // clock period
	localparam int WP_NS = 100; // least write strobe low
	localparam int WPH_NS = 50; // least write strobe high
	localparam int ACC_NS = 150; // read access, slower grade
	localparam int BLC_US = 150; // byte_load_window, longest
	localparam int WC_MS = 10; // program_cycle_time, longest
	localparam int WP_CYC = (WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WPH_CYC = (WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACC_CYC = (ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int BLC_CYC = (BLC_US * 1000) / CLK_PERIOD_NS;
	localparam int WC_CYC = (WC_MS * 1000000) / CLK_PERIOD_NS;
	localparam int CNT_W = 24; // wide enough for WC_CYC
	localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
	localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

	// ----------------------------------------
	// command ops
	// ----------------------------------------
	typedef enum logic [1:0] {
		PEWP_OP_READ,
		PEWP_OP_WRITE,
		PEWP_OP_POLL
	} pewp_op_e;

	// request from the user side
	typedef struct packed {
		pewp_op_e op;
		logic last; // last byte of a page load
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} pewp_req_s;

	// pins driven toward the eeprom
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq;
		logic dq_oe;
	} pewp_pins_s;

endpackage : pewp_pkg

/* File: verif/pewp_eeprom_model.sv */
// eeprom model: page load latch, byte-load window, programming timer, polling
// assumes strobes come from a host that changes pins on clk_i edges
`timescale 1ns/1ps
`default_nettype none
module pewp_eeprom_model #(
	parameter int BLC = 50,
	parameter int WC = 150,
	parameter int ACC = 4,
	// lock command addresses and bytes, values arbitrary
	parameter logic [14:0] CA1 = 15'h0010,
	parameter logic [14:0] CA2 = 15'h0020,
	parameter logic [7:0] CD1 = 8'h01,
	parameter logic [7:0] CD2 = 8'h02,
	parameter logic [7:0] CD_ON = 8'h03,
	parameter logic [7:0] CD_OFF = 8'h04
) (
	// timer clock
	input wire logic clk_i,
	// strobes and address
	input wire logic ce_n_i,
	input wire logic oe_n_i,
	input wire logic we_n_i,
	input wire logic [16:0] addr_i,
	// data lines
	input wire logic [7:0] dq_i,
	output logic [7:0] dq_o,
	output logic dq_oe_o
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0] mem [0:131071]; // array, erased to ff
	logic [16:0] a_q; // latched address
	logic [7:0] last_q; // last byte loaded
	logic [16:0] pa [$]; // page load addresses
	logic [7:0] pd [$]; // page load data
	logic load_q; // window open
	logic prog_q; // programming
	int blc_q; // window timer
	int wc_q; // program timer
	int rc_q; // read access count
	logic lock_q; // plain writes refused while set
	logic cmd_q; // this load opened with a full command sequence
	logic hit_q; // command prefix still matching
	logic [1:0] pend_q; // 1 lock, 2 unlock at end of write
	int n_q; // bytes in this load
	// write only with output drive high
	wire wr = !ce_n_i && !we_n_i && oe_n_i;
	wire rd = !ce_n_i && !oe_n_i && we_n_i;
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
		load_q = 0;
		prog_q = 0;
		rc_q = 0;
		lock_q = 0;
		cmd_q = 0;
		pend_q = 2'h0;
		n_q = 0;
	end
	// address at later fall, settled pins
	always @(posedge wr) #1 a_q = addr_i;
	// data at earlier rise, window restarts
	always @(negedge wr) if (!prog_q) begin
		if (!load_q) begin
			n_q = 0;
			cmd_q = 0;
			pend_q = 2'h0;
		end
		// command bytes on low 15 address lines, data as hex
		case (n_q)
			0: hit_q = a_q[14:0] == CA1 && dq_i == CD1;
			1: hit_q = hit_q && a_q[14:0] == CA2 && dq_i == CD2;
			2: hit_q = hit_q && a_q[14:0] == CA1 && (dq_i == CD_ON || dq_i == CD_OFF);
			default: hit_q = 0;
		endcase
		if (hit_q && n_q == 2) begin
			cmd_q = 1;
			// lock change waits for the end of the write
			pend_q = dq_i == CD_ON ? 2'h1 : 2'h2;
		end else if (!hit_q) begin
			pa.push_back(a_q);
			pd.push_back(dq_i);
		end
		n_q++;
		last_q = dq_i;
		load_q = 1;
		blc_q = 0;
	end
	// window expiry starts a bounded program cycle
	always @(posedge clk_i) begin
		rc_q = rd ? rc_q + 1 : 0;
		if (load_q) begin
			blc_q++;
			if (blc_q >= BLC) begin
				load_q = 0;
				prog_q = 1;
				wc_q = 0;
			end
		end else if (prog_q) begin
			wc_q++;
			if (wc_q >= WC) begin
				prog_q = 0;
				// locked device keeps only prefixed loads
				if (!lock_q || cmd_q) foreach (pa[i]) mem[pa[i]] = pd[i];
				if (pend_q == 2'h1) lock_q = 1;
				if (pend_q == 2'h2) lock_q = 0;
				pa.delete();
				pd.delete();
			end
		end
	end
	// drive only on read; poll bit inverted while programming
	always @* begin
		dq_oe_o = rd;
		dq_o = prog_q ? {~last_q[7], last_q[6:0]} : mem[addr_i];
		if (rc_q < ACC) dq_o = ~dq_o; // slow answer, not yet valid
	end
endmodule // pewp_eeprom_model
`default_nettype wire

/* File: verif/pewp_host_tb.sv */
// testbench for the eeprom host controller
// assumes the eeprom model file is compiled first
`timescale 1ns/1ps
`default_nettype none
module pewp_host_tb;
	logic clk_i, rst_n_i, req_valid_i, req_ready_o, rsp_valid_o, busy_o, page_err_o;
	logic ce_n_o, oe_n_o, we_n_o, data_lines_oe_o, m_oe;
	pewp_pkg::pewp_req_s req_i; // request carrier
	logic [7:0] rsp_data_o, data_lines_o, data_lines_i, m_dq, last_dq;
	logic [16:0] addr_o;
	int num_errors, checked;
	// lock command addresses and bytes, values arbitrary
	localparam logic [14:0] CA1 = 15'h0010;
	localparam logic [14:0] CA2 = 15'h0020;
	localparam logic [7:0] CD1 = 8'h01;
	localparam logic [7:0] CD2 = 8'h02;
	localparam logic [7:0] CD_ON = 8'h03;
	localparam logic [7:0] CD_OFF = 8'h04;
	// released lines show the inverse of the last value
	assign data_lines_i = data_lines_oe_o ? data_lines_o : m_oe ? m_dq : ~last_dq;
	always @(posedge clk_i) if (data_lines_oe_o || m_oe) last_dq <= data_lines_i;
	pewp_host #(.BLC_CYCLES(50), .WC_CYCLES(200)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
		.rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .busy_o(busy_o),
		.page_err_o(page_err_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o),
		.addr_o(addr_o), .data_lines_o(data_lines_o), .data_lines_oe_o(data_lines_oe_o),
		.data_lines_i(data_lines_i));
	pewp_eeprom_model #(.BLC(50), .WC(150), .ACC(4), .CA1(CA1), .CA2(CA2), .CD1(CD1),
		.CD2(CD2), .CD_ON(CD_ON), .CD_OFF(CD_OFF)) mdl (.clk_i(clk_i), .ce_n_i(ce_n_o),
		.oe_n_i(oe_n_o), .we_n_i(we_n_o), .addr_i(addr_o), .dq_i(data_lines_o),
		.dq_o(m_dq), .dq_oe_o(m_oe));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// which: 0 ready, 1 answer, 2 idle
	task automatic wait_for(input int which, input int bound);
		int n;
		logic ok;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
			ok = which == 0 ? req_ready_o === 1'b1 : which == 1 ? rsp_valid_o === 1'b1 :
				req_ready_o === 1'b1 && busy_o === 1'b0;
		end while (!ok && n < bound);
		if (!ok) begin
			num_errors++;
			complete_run();
		end
	endtask
	task automatic send(input pewp_pkg::pewp_op_e op, input logic last, input logic [16:0] a,
		input logic [7:0] d);
		@(posedge clk_i);
		req_valid_i <= 1'b1;
		req_i <= '{op: op, last: last, addr: a, data: d};
		wait_for(0, 400);
		@(posedge clk_i);
		req_valid_i <= 1'b0;
	endtask
	task automatic read_chk(input pewp_pkg::pewp_op_e op, input logic [16:0] a,
		input logic [7:0] exp);
		send(op, 1'b0, a, 8'h00);
		wait_for(1, 40);
		check(rsp_data_o, exp);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		@(negedge clk_i);
		check({ce_n_o, oe_n_o, we_n_o, req_ready_o, busy_o, page_err_o}, 6'h3c);
	endtask
	task automatic t_byte();
		send(pewp_pkg::PEWP_OP_WRITE, 1'b1, 17'h00123, 8'ha5);
		@(negedge clk_i);
		check(busy_o, 1'b1);
		wait_for(2, 2000);
		read_chk(pewp_pkg::PEWP_OP_POLL, 17'h00123, 8'h01);
		read_chk(pewp_pkg::PEWP_OP_READ, 17'h00123, 8'ha5);
	endtask
	task automatic t_page();
		logic [16:0] a [3] = '{17'h1f80, 17'h1fff, 17'h1f81};
		logic [7:0] d [3] = '{8'h3c, 8'hc3, 8'h5a};
		for (int i = 0; i < 3; i++) send(pewp_pkg::PEWP_OP_WRITE, i == 2, a[i], d[i]);
		wait_for(2, 2000);
		for (int i = 0; i < 3; i++) read_chk(pewp_pkg::PEWP_OP_READ, a[i], d[i]);
	endtask
	task automatic t_mismatch();
		send(pewp_pkg::PEWP_OP_WRITE, 1'b0, 17'h00200, 8'h11);
		send(pewp_pkg::PEWP_OP_WRITE, 1'b0, 17'h00280, 8'h22);
		@(negedge clk_i);
		check(page_err_o, 1'b1);
		wait_for(2, 2000);
		// first poll lands inside the program cycle, then poll to done
		read_chk(pewp_pkg::PEWP_OP_POLL, 17'h00200, 8'h00);
		for (int i = 0; i < 40 && rsp_data_o !== 8'h01; i++) begin
			send(pewp_pkg::PEWP_OP_POLL, 1'b0, 17'h00200, 8'h00);
			wait_for(1, 40);
		end
		check(rsp_data_o, 8'h01);
		read_chk(pewp_pkg::PEWP_OP_READ, 17'h00200, 8'h11);
		read_chk(pewp_pkg::PEWP_OP_READ, 17'h00280, 8'hff);
	endtask
	// three-byte lock command, closing the load when last is set
	task automatic cmd_seq(input logic [7:0] d3, input logic last);
		send(pewp_pkg::PEWP_OP_WRITE, 1'b0, {2'h0, CA1}, CD1);
		send(pewp_pkg::PEWP_OP_WRITE, 1'b0, {2'h0, CA2}, CD2);
		send(pewp_pkg::PEWP_OP_WRITE, last, {2'h0, CA1}, d3);
		if (last) wait_for(2, 2000);
	endtask
	// lock, refused plain write, prefixed write, unlock
	task automatic t_lock();
		cmd_seq(CD_ON, 1'b1);
		send(pewp_pkg::PEWP_OP_WRITE, 1'b1, 17'h00030, 8'h77);
		wait_for(2, 2000);
		read_chk(pewp_pkg::PEWP_OP_READ, 17'h00030, 8'hff);
		cmd_seq(CD_ON, 1'b0);
		send(pewp_pkg::PEWP_OP_WRITE, 1'b1, 17'h00030, 8'h77);
		wait_for(2, 2000);
		read_chk(pewp_pkg::PEWP_OP_READ, 17'h00030, 8'h77);
		cmd_seq(CD_OFF, 1'b1);
		send(pewp_pkg::PEWP_OP_WRITE, 1'b1, 17'h00031, 8'h66);
		wait_for(2, 2000);
		read_chk(pewp_pkg::PEWP_OP_READ, 17'h00031, 8'h66);
		read_chk(pewp_pkg::PEWP_OP_READ, {2'h0, CA1}, 8'hff);
	endtask
	// output drive stays high through every write strobe
	always @(negedge clk_i) if (rst_n_i && !ce_n_o && !we_n_o) check(oe_n_o, 1'b1);
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// main sequence
	initial begin
		rst_n_i = 1'b0;
		req_valid_i = 1'b0;
		req_i = '0;
		last_dq = 8'h00;
		num_errors = 0;
		checked = 0;
		t_reset();
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_byte();
		t_page();
		t_mismatch();
		t_lock();
		complete_run();
	end
endmodule // pewp_host_tb
`default_nettype wire
